// file: dv/board_irq_router_test.sv
// self-checking bench for the board interrupt routing block
module board_irq_router_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [4:0] src; logic [2:0] r; logic [7:0] exp;} row_t;
  logic        clk, rstn, wr, rd, hw_en, nmi, irq;
  logic [7:0]  addr, req, oe, obus, lines_n, pull;
  logic [31:0] wdata, rdata;
  logic [14:0] pins;
  int          err_count, comparisons;
  row_t        rows [17];

  board_irq_router dut (
    .sys_clk_in(clk), .rstn_in(rstn), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .timer_a_irq_in(pins[0]),
    .timer_b_irq_in(pins[1]), .serial_tx_ready_irq_in(pins[2]),
    .serial_rx_ready_irq_in(pins[3]), .par_port_a_irq_in(pins[4]),
    .par_port_b_irq_in(pins[5]), .module_a_irq0_in(pins[6]), .module_a_irq1_in(pins[7]),
    .module_b_irq0_in(pins[8]), .module_b_irq1_in(pins[9]), .power_line_tick_in(pins[10]),
    .power_fail_irq_n_in(pins[11]), .math_unit_irq_in(pins[12]), .external_irq_in(pins[13]),
    .bus_timeout_irq_n_in(pins[14]), .nmi_hw_enable_in(hw_en), .bus_irq_n_in(lines_n),
    .bus_irq_n_out(obus), .bus_irq_n_oe_out(oe), .ctrl_req_out(req), .nmi_out(nmi),
    .irq_out(irq));
  bus_line_model bus (.oe_in(oe), .pull_in(pull), .lines_n_out(lines_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude;
    $display("mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: output %h, wanted %h", $time, got, exp);
    end
  endtask : chk8

  function automatic logic [7:0] route_a(input logic [2:0] r);
    return irq_router_pkg::OFS_ROUTE_BASE + {3'h0, r, 2'h0};
  endfunction : route_a

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk32(rdata, e);
  endtask : rd_chk

  // sources in matrix order, bits 17 to 24 are other boards on the bus
  task automatic drive(input logic [24:0] act);
    @(posedge clk);
    pins <= act[14:0] ^ irq_router_pkg::PIN_ACT_LOW;
    pull <= act[24:17];
  endtask : drive

  // three edges from pin to output, one spare
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  task automatic do_reset;
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
  endtask : do_reset

  initial begin
    #500000;
    err_count++;
    conclude();
  end

  initial begin
    err_count = 0;
    comparisons = 0;
    {rstn, wr, rd, hw_en, addr, wdata, pull} = '0;
    pins = irq_router_pkg::PIN_ACT_LOW;
    rows = '{'{5'h00, 3'h5, 8'h24}, '{5'h01, 3'h0, 8'h01}, '{5'h02, 3'h1, 8'h02},
      '{5'h03, 3'h3, 8'h08}, '{5'h04, 3'h4, 8'h10}, '{5'h05, 3'h6, 8'h40},
      '{5'h06, 3'h7, 8'h80}, '{5'h07, 3'h0, 8'h01}, '{5'h08, 3'h1, 8'h02},
      '{5'h09, 3'h3, 8'h08}, '{5'h0A, 3'h4, 8'h10}, '{5'h0B, 3'h5, 8'h20},
      '{5'h0C, 3'h6, 8'h40}, '{5'h0D, 3'h7, 8'h80}, '{5'h0E, 3'h0, 8'h01},
      '{5'h14, 3'h1, 8'h02}, '{5'h18, 3'h3, 8'h08}};
    do_reset();
    foreach (rows[i]) begin
      wr_reg(route_a(rows[i].r), 32'h1 << rows[i].src);
      drive(25'h1 << rows[i].src);
      settle();
      chk8(req, rows[i].exp);
      drive(25'h0);
      wr_reg(route_a(rows[i].r), 32'h0);
    end
    wr_reg(route_a(3'h4), 32'h400);
    repeat (2) begin
      drive(25'h400);
      settle();
      chk8(req, 8'h10);
      drive(25'h0);
      settle();
      chk8(req, 8'h00);
    end
    do_reset();
    rd_chk(irq_router_pkg::OFS_CONTROL, irq_router_pkg::CTRL_RESET);
    rd_chk(irq_router_pkg::OFS_EDGE_SEL, 32'h0000_000E);
    rd_chk(irq_router_pkg::OFS_OR_SEL, 32'h3FFF_FFFF);
    rd_chk(irq_router_pkg::OFS_NMI_ROUTE, 32'h0000_0800);
    rd_chk(route_a(3'h2), 32'h0000_0001);
    rd_chk(8'h40, 32'h0);
    drive(25'h3);
    settle();
    chk8(req, 8'h04);
    wr_reg(irq_router_pkg::OFS_EVENT_MASK, 32'h2);
    drive(25'h800);
    settle();
    chk8({7'h0, nmi}, 8'h01);
    chk8({7'h0, irq}, 8'h01);
    rd_chk(irq_router_pkg::OFS_EVENT, 32'h2);
    wr_reg(irq_router_pkg::OFS_EVENT, 32'h2);
    settle();
    chk8({7'h0, irq}, 8'h00);
    wr_reg(irq_router_pkg::OFS_EVENT_MASK, 32'h0);
    hw_en <= 1'b1;
    wr_reg(irq_router_pkg::OFS_CONTROL, 32'h0000_1010);
    settle();
    chk8({7'h0, nmi}, 8'h00);
    wr_reg(irq_router_pkg::OFS_CONTROL, 32'h0000_1011);
    settle();
    chk8({7'h0, nmi}, 8'h01);
    hw_en <= 1'b0;
    wr_reg(irq_router_pkg::OFS_CONTROL, 32'h0000_1010);
    settle();
    chk8({7'h0, nmi}, 8'h01);
    wr_reg(route_a(3'h0), 32'h0000_2000);
    wr_reg(irq_router_pkg::OFS_CONTROL, 32'h0000_1031);
    drive(25'h0);
    settle();
    chk8(req, 8'h01);
    drive(25'h2000);
    settle();
    chk8(req, 8'h00);
    wr_reg(route_a(3'h0), 32'h0);
    wr_reg(route_a(3'h1), 32'h0200_0000);
    drive(25'h4000);
    drive(25'h0);
    settle();
    settle();
    chk8(req, 8'h02);
    drive(25'h4000);
    drive(25'h0);
    settle();
    chk8(req, 8'h02);
    rd_chk(irq_router_pkg::OFS_STATUS, 32'h1);
    wr_reg(irq_router_pkg::OFS_STATUS, 32'h1);
    settle();
    chk8(req, 8'h00);
    wr_reg(irq_router_pkg::OFS_OR_SEL, 32'h3FFF_93E5);
    wr_reg(route_a(3'h3), 32'h0400_0000);
    wr_reg(route_a(3'h4), 32'h0800_0000);
    drive(25'h10);
    settle();
    chk8(req, 8'h08);
    drive(25'h20);
    settle();
    chk8(req, 8'h10);
    drive(25'h0);
    wr_reg(route_a(3'h6), 32'h0001_0000);
    wr_reg(route_a(3'h7), 32'h0000_8000);
    wr_reg(irq_router_pkg::OFS_CONTROL, 32'h0000_3516);
    settle();
    chk8(oe, 8'h28);
    chk8(lines_n, 8'hD7);
    chk8(obus, 8'h00);
    chk8(req, 8'h40);
    wr_reg(irq_router_pkg::OFS_CONTROL, 32'h0000_351E);
    settle();
    chk8(req, 8'hC0);
    wr_reg(irq_router_pkg::OFS_CONTROL, 32'h0000_1010);
    settle();
    chk8(oe, 8'h00);
    conclude();
  end
endmodule : board_irq_router_test

// file: dv/bus_line_model.sv
// open-collector bus interrupt lines with pull-ups, shared with other boards
module bus_line_model (
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] pull_in,
  output logic      [7:0] lines_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // pulled up unless this board or another board sinks the line
  assign lines_n_out = ~(oe_in | pull_in);
endmodule : bus_line_model

// file: dv/irq_router_props.sv
// concurrent checks on the routing block register port and bus outputs
module irq_router_props (
  input wire logic                              sys_clk_in,
  input wire logic                              rstn_in,
  input wire logic [irq_router_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [irq_router_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic                              reg_wr_in,
  input wire logic                              reg_rd_in,
  input wire logic [irq_router_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic [irq_router_pkg::NUM_BUS-1:0] bus_irq_n_out,
  input wire logic [irq_router_pkg::NUM_BUS-1:0] bus_irq_n_oe_out,
  input wire logic [irq_router_pkg::NUM_REQ-1:0] ctrl_req_out,
  input wire logic                              nmi_out,
  input wire logic                              irq_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // bus lines that a control word asks to pull low
  function automatic logic [7:0] sw_lines(input logic [31:0] c);
    sw_lines = (c[1] ? 8'h01 << c[10:8] : 8'h00) | (c[2] ? 8'h01 << c[14:12] : 8'h00);
  endfunction : sw_lines
  rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data seen outside its cycle");
  bus_low_only_a: assert property (bus_irq_n_out == 8'h00)
    else $error("bus line driven high");
  two_drivers_a: assert property ($countones(bus_irq_n_oe_out) <= 2)
    else $error("more than two bus lines pulled");
  oe_cause_a: assert property ($changed(bus_irq_n_oe_out) |->
    $past(reg_wr_in, 2) && $past(reg_addr_in, 2) == irq_router_pkg::OFS_CONTROL)
    else $error("bus pull changed without a control write");
  sw_line_set_a: assert property (reg_wr_in && reg_addr_in == irq_router_pkg::OFS_CONTROL
    |-> ##2 bus_irq_n_oe_out == sw_lines($past(reg_wdata_in, 2)))
    else $error("bus pull differs from control word");
  mask_off_irq_a: assert property (reg_wr_in && reg_wdata_in == 32'h0 &&
    reg_addr_in == irq_router_pkg::OFS_EVENT_MASK |-> ##2 !irq_out)
    else $error("interrupt high with all events masked");
  ctrl_resv_zero_a: assert property (reg_rd_in
    && reg_addr_in == irq_router_pkg::OFS_CONTROL
    |=> (reg_rdata_out & ~irq_router_pkg::CTRL_WR_MASK) == 32'h0)
    else $error("reserved control bits read nonzero");
  stat_resv_zero_a: assert property (reg_rd_in && reg_addr_in == irq_router_pkg::OFS_STATUS
    |=> reg_rdata_out[31:3] == 29'h0)
    else $error("reserved status bits read nonzero");
  edge_sel_resv_a: assert property (reg_rd_in
    && reg_addr_in == irq_router_pkg::OFS_EDGE_SEL
    |=> reg_rdata_out[31:5] == 27'h0)
    else $error("reserved edge select bits read nonzero");
  irq_seen_c: cover property ($rose(irq_out));
  nmi_seen_c: cover property ($rose(nmi_out));
  pull_seen_c: cover property (bus_irq_n_oe_out != 8'h00);
  latch_seen_c: cover property ($rose(ctrl_req_out[1]));
endmodule : irq_router_props

bind board_irq_router irq_router_props props (.sys_clk_in, .rstn_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .bus_irq_n_out, .bus_irq_n_oe_out,
  .ctrl_req_out, .nmi_out, .irq_out);

// file: logic/board_irq_router.sv
// board interrupt routing matrix with register port
// What this block does
// [R1] a rising edge on the chosen source sets a latch holding a level request
// [R2] the latch holds until software clears it; set beats clear
// [R3] mask gate high passes the NMI source, low blocks every NMI
// [R4] software mask bit applies only while the hardware enable pin is high
// [R5] two software bus interrupt outputs set and released by control bits
// [R6] bus lines only pulled low, only by the two software outputs
// [R7] second software output reaches the matrix by default, first needs enabling
// [R8] any bus interrupt input routes to any controller request 0 to 7
// [R9] serial ready levels pass through as requests while asserted
// [R10] after reset timer a feeds request 2, timer b goes nowhere
// [R11] line tick arrives from the chassis as a periodic level
// [R12] power fail input routes to the NMI output by default
// [R13] external input passes an optional inverter before routing
// [R14] each expansion module gives two separate request lines
// [R15] parallel port lines route to any chosen controller request
// [R16] combiner a ORs inputs 2 to 5, combiner b ORs inputs 0 and 1
module board_irq_router (
  input  wire logic                                  sys_clk_in,
  input  wire logic                                  rstn_in,
  input  wire logic [irq_router_pkg::ADDR_W-1:0]     reg_addr_in,
  input  wire logic [irq_router_pkg::DATA_W-1:0]     reg_wdata_in,
  input  wire logic                                  reg_wr_in,
  input  wire logic                                  reg_rd_in,
  output logic      [irq_router_pkg::DATA_W-1:0]     reg_rdata_out,
  input  wire logic                                  timer_a_irq_in,
  input  wire logic                                  timer_b_irq_in,
  input  wire logic                                  serial_tx_ready_irq_in,
  input  wire logic                                  serial_rx_ready_irq_in,
  input  wire logic                                  par_port_a_irq_in,
  input  wire logic                                  par_port_b_irq_in,
  input  wire logic                                  module_a_irq0_in,
  input  wire logic                                  module_a_irq1_in,
  input  wire logic                                  module_b_irq0_in,
  input  wire logic                                  module_b_irq1_in,
  input  wire logic                                  power_line_tick_in,
  input  wire logic                                  power_fail_irq_n_in,
  input  wire logic                                  math_unit_irq_in,
  input  wire logic                                  external_irq_in,
  input  wire logic                                  bus_timeout_irq_n_in,
  input  wire logic                                  nmi_hw_enable_in,
  input  wire logic [irq_router_pkg::NUM_BUS-1:0]    bus_irq_n_in,
  output logic      [irq_router_pkg::NUM_BUS-1:0]    bus_irq_n_out,
  output logic      [irq_router_pkg::NUM_BUS-1:0]    bus_irq_n_oe_out,
  output logic      [irq_router_pkg::NUM_REQ-1:0]    ctrl_req_out,
  output logic                                       nmi_out,
  output logic                                       irq_out
);
  typedef struct packed {
    logic [irq_router_pkg::RAW_W-1:0]                            sync_a;
    logic [irq_router_pkg::RAW_W-1:0]                            sync_b;
    logic [irq_router_pkg::DATA_W-1:0]                           control;
    logic [irq_router_pkg::EV_W-1:0]                             event_flags;
    logic [irq_router_pkg::EV_W-1:0]                             event_mask;
    logic [irq_router_pkg::SEL_W-1:0]                            edge_sel;
    logic [irq_router_pkg::NUM_OR*irq_router_pkg::SEL_W-1:0]     or_sel;
    logic [irq_router_pkg::NUM_SRC-1:0]                          nmi_route;
    logic [irq_router_pkg::NUM_REQ-1:0][irq_router_pkg::NUM_SRC-1:0] route;
    logic                                                        edge_prev;
    logic                                                        nmi_prev;
    logic                                                        timeout_prev;
    logic [irq_router_pkg::NUM_REQ-1:0]                          req;
    logic                                                        nmi;
    logic [irq_router_pkg::NUM_BUS-1:0]                          bus_level;
    logic [irq_router_pkg::NUM_BUS-1:0]                          bus_oe;
    logic                                                        irq;
    logic [irq_router_pkg::DATA_W-1:0]                           rdata;
  } router_state_t;

  router_state_t                          s;
  router_state_t                          next_s;
  logic [irq_router_pkg::RAW_W-1:0]       raw;
  logic [irq_router_pkg::NUM_SRC-1:0]     src;
  logic [irq_router_pkg::NUM_OR-1:0]      or_in;
  logic [irq_router_pkg::EV_W-1:0]        ev_set;
  logic [irq_router_pkg::EV_W-1:0]        ev_clr;
  logic                                   mask_gate;
  logic                                   edge_sample;
  logic                                   edge_clear;

  edge_conv_if edge_link ();

  edge_level_conv u_edge_conv (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .link       (edge_link.conv)
  );

  assign edge_link.sample = edge_sample;
  assign edge_link.clear  = edge_clear;

  // pick one base source by select code, codes past the base list give zero
  function automatic logic pick_src(
    input logic [irq_router_pkg::SEL_W-1:0]   sel,
    input logic [irq_router_pkg::NUM_SRC-1:0] vec
  );
    logic hit;
    hit = 1'b0;
    if (sel < irq_router_pkg::SEL_W'(irq_router_pkg::NUM_BASE)) begin
      hit = vec[sel];
    end
    return hit;
  endfunction : pick_src

  // any source enabled in a route mask
  function automatic logic any_routed(
    input logic [irq_router_pkg::NUM_SRC-1:0] mask,
    input logic [irq_router_pkg::NUM_SRC-1:0] vec
  );
    return |(mask & vec);
  endfunction : any_routed

  // one-hot decode of a bus line select
  function automatic logic [irq_router_pkg::NUM_BUS-1:0] line_hot(
    input logic [irq_router_pkg::LINE_W-1:0] line
  );
    logic [irq_router_pkg::NUM_BUS-1:0] hot;
    hot = '0;
    hot[line] = 1'b1;
    return hot;
  endfunction : line_hot

  // every pin is asynchronous to the board clock
  assign raw = {nmi_hw_enable_in, bus_irq_n_in, bus_timeout_irq_n_in, external_irq_in,
                math_unit_irq_in, power_fail_irq_n_in, power_line_tick_in,
                module_b_irq1_in, module_b_irq0_in, module_a_irq1_in, module_a_irq0_in,
                par_port_b_irq_in, par_port_a_irq_in, serial_rx_ready_irq_in,
                serial_tx_ready_irq_in, timer_b_irq_in, timer_a_irq_in};

  always_comb begin
    next_s = s;
    src    = '0;
    or_in  = '0;
    ev_set = '0;
    ev_clr = '0;
    next_s.sync_a = raw;
    next_s.sync_b = s.sync_a;

    // pin sources, active-low ones turned to active high
    src[irq_router_pkg::PIN_W-1:0] =
      s.sync_b[irq_router_pkg::PIN_W-1:0] ^ irq_router_pkg::PIN_ACT_LOW; // [R9] [R11] [R14] [R15]
    src[irq_router_pkg::SRC_EXTERNAL] = s.sync_b[irq_router_pkg::SRC_EXTERNAL]
                                        ^ s.control[irq_router_pkg::CTRL_EXT_INV]; // [R13]
    src[irq_router_pkg::SRC_SW_A] = s.control[irq_router_pkg::CTRL_SW_A]
                                    & s.control[irq_router_pkg::CTRL_SW_A_MTX]; // [R7]
    src[irq_router_pkg::SRC_SW_B] = s.control[irq_router_pkg::CTRL_SW_B]
                                    & s.control[irq_router_pkg::CTRL_SW_B_MTX]; // [R7]
    src[irq_router_pkg::SRC_BUS0 +: irq_router_pkg::NUM_BUS] =
      ~s.sync_b[irq_router_pkg::RAW_BUS +: irq_router_pkg::NUM_BUS]; // [R8]

    // combiner inputs draw on base sources only, so no loop can form
    for (int i = 0; i < irq_router_pkg::NUM_OR; i++) begin
      or_in[i] = pick_src(s.or_sel[i*irq_router_pkg::SEL_W +: irq_router_pkg::SEL_W], src);
    end
    src[irq_router_pkg::SRC_EDGE] = edge_link.level; // [R1]
    src[irq_router_pkg::SRC_OR_A] = |or_in[5:2]; // [R16]
    src[irq_router_pkg::SRC_OR_B] = or_in[0] | or_in[1]; // [R16]

    edge_sample = pick_src(s.edge_sel, src); // [R1]
    edge_clear  = reg_wr_in && (reg_addr_in == irq_router_pkg::OFS_STATUS)
                  && reg_wdata_in[irq_router_pkg::STAT_EDGE]; // [R2]

    // controller requests
    for (int r = 0; r < irq_router_pkg::NUM_REQ; r++) begin
      next_s.req[r] = any_routed(s.route[r], src); // [R8] [R10] [R15]
    end

    // nmi mask gate, software bit counts only with hardware enable
    mask_gate = s.sync_b[irq_router_pkg::RAW_HWEN]
                ? s.control[irq_router_pkg::CTRL_NMI_MASK] : 1'b1; // [R4]
    next_s.nmi = any_routed(s.nmi_route, src) & mask_gate; // [R3] [R12]

    // software bus outputs pull their chosen line low, never drive high
    next_s.bus_level = '0; // [R6]
    next_s.bus_oe = '0;
    if (s.control[irq_router_pkg::CTRL_SW_A]) begin
      next_s.bus_oe = next_s.bus_oe | line_hot(
        s.control[irq_router_pkg::CTRL_LINE_A +: irq_router_pkg::LINE_W]); // [R5] [R6]
    end
    if (s.control[irq_router_pkg::CTRL_SW_B]) begin
      next_s.bus_oe = next_s.bus_oe | line_hot(
        s.control[irq_router_pkg::CTRL_LINE_B +: irq_router_pkg::LINE_W]); // [R5] [R6]
    end

    // sticky events, a set in the clearing cycle survives
    next_s.edge_prev    = edge_link.level;
    next_s.nmi_prev     = s.nmi;
    next_s.timeout_prev = src[irq_router_pkg::SRC_TIMEOUT];
    ev_set[irq_router_pkg::EV_EDGE]    = edge_link.level & ~s.edge_prev;
    ev_set[irq_router_pkg::EV_NMI]     = s.nmi & ~s.nmi_prev;
    ev_set[irq_router_pkg::EV_TIMEOUT] = src[irq_router_pkg::SRC_TIMEOUT] & ~s.timeout_prev;
    if (reg_wr_in && (reg_addr_in == irq_router_pkg::OFS_EVENT)) begin
      ev_clr = reg_wdata_in[irq_router_pkg::EV_W-1:0];
    end
    next_s.event_flags = (s.event_flags & ~ev_clr) | ev_set;

    // register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        irq_router_pkg::OFS_CONTROL: begin
          next_s.control = reg_wdata_in & irq_router_pkg::CTRL_WR_MASK; // [R4] [R5]
        end
        irq_router_pkg::OFS_EVENT_MASK: begin
          next_s.event_mask = reg_wdata_in[irq_router_pkg::EV_W-1:0];
        end
        irq_router_pkg::OFS_EDGE_SEL: begin
          next_s.edge_sel = reg_wdata_in[irq_router_pkg::SEL_W-1:0];
        end
        irq_router_pkg::OFS_OR_SEL: begin
          next_s.or_sel = reg_wdata_in[irq_router_pkg::NUM_OR*irq_router_pkg::SEL_W-1:0];
        end
        irq_router_pkg::OFS_NMI_ROUTE: begin
          next_s.nmi_route = reg_wdata_in[irq_router_pkg::NUM_SRC-1:0];
        end
        default: begin
          for (int r = 0; r < irq_router_pkg::NUM_REQ; r++) begin
            if (reg_addr_in == irq_router_pkg::OFS_ROUTE_BASE
                + irq_router_pkg::ADDR_W'(r << irq_router_pkg::ROUTE_STRIDE_LSB)) begin
              next_s.route[r] = reg_wdata_in[irq_router_pkg::NUM_SRC-1:0]; // [R8]
            end
          end
        end
      endcase
    end

    // register reads, data valid in the following cycle only
    next_s.rdata = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        irq_router_pkg::OFS_CONTROL: begin
          next_s.rdata = s.control;
        end
        irq_router_pkg::OFS_STATUS: begin
          next_s.rdata[irq_router_pkg::STAT_EDGE]  = edge_link.level;
          next_s.rdata[irq_router_pkg::STAT_HW_EN] = s.sync_b[irq_router_pkg::RAW_HWEN];
          next_s.rdata[irq_router_pkg::STAT_NMI]   = s.nmi;
        end
        irq_router_pkg::OFS_EVENT: begin
          next_s.rdata[irq_router_pkg::EV_W-1:0] = s.event_flags;
        end
        irq_router_pkg::OFS_EVENT_MASK: begin
          next_s.rdata[irq_router_pkg::EV_W-1:0] = s.event_mask;
        end
        irq_router_pkg::OFS_EDGE_SEL: begin
          next_s.rdata[irq_router_pkg::SEL_W-1:0] = s.edge_sel;
        end
        irq_router_pkg::OFS_OR_SEL: begin
          next_s.rdata[irq_router_pkg::NUM_OR*irq_router_pkg::SEL_W-1:0] = s.or_sel;
        end
        irq_router_pkg::OFS_NMI_ROUTE: begin
          next_s.rdata[irq_router_pkg::NUM_SRC-1:0] = s.nmi_route;
        end
        irq_router_pkg::OFS_SOURCES: begin
          next_s.rdata[irq_router_pkg::NUM_SRC-1:0] = src;
        end
        default: begin
          for (int r = 0; r < irq_router_pkg::NUM_REQ; r++) begin
            if (reg_addr_in == irq_router_pkg::OFS_ROUTE_BASE
                + irq_router_pkg::ADDR_W'(r << irq_router_pkg::ROUTE_STRIDE_LSB)) begin
              next_s.rdata[irq_router_pkg::NUM_SRC-1:0] = s.route[r];
            end
          end
        end
      endcase
    end

    next_s.irq = |(next_s.event_flags & s.event_mask);
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      s           <= '0;
      {s.sync_a, s.sync_b} <= {2{1'b0, {irq_router_pkg::NUM_BUS{1'b1}},
                                 irq_router_pkg::PIN_ACT_LOW}};
      s.control   <= irq_router_pkg::CTRL_RESET; // [R7]
      s.edge_sel  <= irq_router_pkg::EDGE_SEL_RESET;
      s.or_sel    <= irq_router_pkg::OR_SEL_RESET;
      s.nmi_route <= irq_router_pkg::NMI_ROUTE_RESET; // [R12]
      s.route[irq_router_pkg::TIMER_A_REQ] <= irq_router_pkg::TIMER_A_ROUTE; // [R10]
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_out    = s.rdata;
  assign bus_irq_n_out    = s.bus_level;
  assign bus_irq_n_oe_out = s.bus_oe;
  assign ctrl_req_out     = s.req;
  assign nmi_out          = s.nmi;
  assign irq_out          = s.irq;
endmodule : board_irq_router

// file: logic/edge_conv_if.sv
// carrier between the router and its edge-to-level converter
interface edge_conv_if;
  logic sample;
  logic clear;
  logic level;

  modport owner (output sample, output clear, input level);
  modport conv  (input sample, input clear, output level);
endinterface : edge_conv_if

// file: logic/edge_level_conv.sv
// edge-to-level converter latch
module edge_level_conv (
  input  wire logic  sys_clk_in,
  input  wire logic  rstn_in,
  edge_conv_if.conv  link
);
  typedef struct packed {
    logic prev;
    logic latch;
  } conv_state_t;

  conv_state_t s;
  conv_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.prev = link.sample;
    if (link.sample && !s.prev) begin
      next_s.latch = 1'b1; // [R1] [R2]
    end else if (link.clear) begin
      next_s.latch = 1'b0; // [R2]
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.level = s.latch;
endmodule : edge_level_conv

// file: logic/irq_router_pkg.sv
// constants shared by the interrupt routing block, its property checks and its bench
package irq_router_pkg;
  // widths and counts
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned NUM_REQ  = 8;
  localparam int unsigned NUM_BUS  = 8;
  localparam int unsigned NUM_OR   = 6;
  localparam int unsigned NUM_SRC  = 28;
  localparam int unsigned NUM_BASE = 25;
  localparam int unsigned SEL_W    = 5;
  localparam int unsigned LINE_W   = 3;
  localparam int unsigned EV_W     = 3;
  localparam int unsigned PIN_W    = 15;
  localparam int unsigned RAW_W    = 24;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EVENT      = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_EDGE_SEL   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OR_SEL     = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_NMI_ROUTE  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SOURCES    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_ROUTE_BASE = 8'h20;
  localparam int unsigned       ROUTE_STRIDE_LSB = 2;

  // control register fields
  localparam int unsigned CTRL_NMI_MASK  = 0;
  localparam int unsigned CTRL_SW_A      = 1;
  localparam int unsigned CTRL_SW_B      = 2;
  localparam int unsigned CTRL_SW_A_MTX  = 3;
  localparam int unsigned CTRL_SW_B_MTX  = 4;
  localparam int unsigned CTRL_EXT_INV   = 5;
  localparam int unsigned CTRL_LINE_A    = 8;
  localparam int unsigned CTRL_LINE_B    = 12;
  localparam logic [DATA_W-1:0] CTRL_WR_MASK = 32'h0000_773F;
  localparam logic [DATA_W-1:0] CTRL_RESET   = 32'h0000_1011;

  // status register fields
  localparam int unsigned STAT_EDGE  = 0;
  localparam int unsigned STAT_HW_EN = 1;
  localparam int unsigned STAT_NMI   = 2;

  // event bits
  localparam int unsigned EV_EDGE    = 0;
  localparam int unsigned EV_NMI     = 1;
  localparam int unsigned EV_TIMEOUT = 2;

  // source indices in the routing matrix
  localparam int unsigned SRC_TIMER_A    = 0;
  localparam int unsigned SRC_TIMER_B    = 1;
  localparam int unsigned SRC_SER_TX     = 2;
  localparam int unsigned SRC_SER_RX     = 3;
  localparam int unsigned SRC_PAR_A      = 4;
  localparam int unsigned SRC_PAR_B      = 5;
  localparam int unsigned SRC_MOD_A0     = 6;
  localparam int unsigned SRC_MOD_A1     = 7;
  localparam int unsigned SRC_MOD_B0     = 8;
  localparam int unsigned SRC_MOD_B1     = 9;
  localparam int unsigned SRC_LINE_TICK  = 10;
  localparam int unsigned SRC_POWER_FAIL = 11;
  localparam int unsigned SRC_MATH       = 12;
  localparam int unsigned SRC_EXTERNAL   = 13;
  localparam int unsigned SRC_TIMEOUT    = 14;
  localparam int unsigned SRC_SW_A       = 15;
  localparam int unsigned SRC_SW_B       = 16;
  localparam int unsigned SRC_BUS0       = 17;
  localparam int unsigned SRC_EDGE       = 25;
  localparam int unsigned SRC_OR_A       = 26;
  localparam int unsigned SRC_OR_B       = 27;

  // raw input vector layout
  localparam int unsigned RAW_BUS  = 15;
  localparam int unsigned RAW_HWEN = 23;
  localparam logic [PIN_W-1:0] PIN_ACT_LOW = 15'h4800;

  // reset values
  localparam logic [SEL_W-1:0]         SEL_NONE        = 5'h1F;
  localparam logic [SEL_W-1:0]         EDGE_SEL_RESET  = 5'h0E;
  localparam logic [NUM_SRC-1:0]       NMI_ROUTE_RESET = 28'h000_0800;
  localparam logic [NUM_SRC-1:0]       TIMER_A_ROUTE   = 28'h000_0001;
  localparam int unsigned              TIMER_A_REQ     = 2;
  localparam logic [NUM_OR*SEL_W-1:0]  OR_SEL_RESET    = 30'h3FFF_FFFF;
endpackage : irq_router_pkg
